// File: hdl/tdw_pkg.sv
// Overview of operation
// - Descriptor is four words: status, control, buffers
// - Word 0 bit 31: 1 core, 0 host
// - Clear holder bit at frame or buffer end
// - Error summary ORs five error bits
// - Status valid only in last descriptor
// - Bit 11 set when carrier drops
// - Bit 10 set when carrier never seen
// - Bit 9 set on collision after 64 bytes
// - Abort after 16 retries, set bit 8
// - Bits 6..3 hold collision count
// - Bit 1 set when FIFO runs empty
// - Bit 0 set when start was deferred
// - Word 1 bit 30 last, bit 29 first
package tdw_pkg;
  // ==========================================================
  // Descriptor layout
  localparam logic [3:0]  DESC_WORDS      = 4'h4;
  localparam logic [31:0] OFF_STATUS      = 32'h0000_0000;
  localparam logic [31:0] OFF_CONTROL     = 32'h0000_0004;
  localparam logic [31:0] OFF_BUF1        = 32'h0000_0008;
  localparam logic [31:0] OFF_BUF2        = 32'h0000_000c;
  localparam int          BIT_HOLDER      = 31;
  localparam int          BIT_ANY_ERR     = 15;
  localparam int          BIT_CARR_DROP   = 11;
  localparam int          BIT_NO_CARR     = 10;
  localparam int          BIT_LATE_COLL   = 9;
  localparam int          BIT_RETRY_ABORT = 8;
  localparam int          BIT_TALLY_HI    = 6;
  localparam int          BIT_TALLY_LO    = 3;
  localparam int          BIT_STARVED     = 1;
  localparam int          BIT_POSTPONED   = 0;
  localparam int          BIT_FINAL_DESC  = 30;
  localparam int          BIT_FIRST_DESC  = 29;
  // ==========================================================
  // Collision limits
  localparam logic [4:0]  RETRY_LIMIT     = 5'h10;
  localparam logic [7:0]  LATE_BYTES      = 8'h40;
  // ==========================================================
  // Register map
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_BASE        = 8'h04;
  localparam logic [7:0]  REG_STAT        = 8'h08;
  localparam logic [7:0]  REG_IRQ         = 8'h0c;
  localparam logic [7:0]  REG_MASK        = 8'h10;
  localparam logic [7:0]  REG_LAST_WB     = 8'h14;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
  localparam logic [2:0]  IRQ_W           = 3'h3;

  typedef struct packed {
    logic       carrier_dropped;
    logic       no_carrier;
    logic       late_collision;
    logic       fifo_starved;
    logic       start_postponed;
    logic       collision;
    logic       frame_end;
  } tdw_txev_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_WAITF = 3'b010,
    ST_BUSY  = 3'b011,
    ST_WBACK = 3'b100,
    ST_WAITW = 3'b101
  } tdw_state_t;
endpackage : tdw_pkg

// File: hdl/tdw_status_pack.sv
module tdw_status_pack
  import tdw_pkg::*;
(
  input  wire logic        final_desc,
  input  wire logic        carrier_dropped,
  input  wire logic        no_carrier,
  input  wire logic        late_collision,
  input  wire logic        retry_limit_abort,
  input  wire logic [3:0]  collision_tally,
  input  wire logic        fifo_starved,
  input  wire logic        start_postponed,
  output logic      [31:0] tx_desc_status_word
);
  logic any_error_flag;

  always_comb begin
    any_error_flag = fifo_starved | retry_limit_abort | late_collision
                   | no_carrier | carrier_dropped;
    tx_desc_status_word = 32'h0000_0000;
    tx_desc_status_word[BIT_HOLDER] = 1'b0;
    if (final_desc) begin
      tx_desc_status_word[BIT_ANY_ERR]     = any_error_flag;
      tx_desc_status_word[BIT_CARR_DROP]   = carrier_dropped;
      tx_desc_status_word[BIT_NO_CARR]     = no_carrier;
      tx_desc_status_word[BIT_LATE_COLL]   = late_collision;
      tx_desc_status_word[BIT_RETRY_ABORT] = retry_limit_abort;
      tx_desc_status_word[BIT_TALLY_HI:BIT_TALLY_LO] = collision_tally;
      tx_desc_status_word[BIT_STARVED]     = fifo_starved;
      tx_desc_status_word[BIT_POSTPONED]   = start_postponed;
    end
  end
endmodule : tdw_status_pack

// File: hdl/tdw_writeback.sv
// The address map and the AXI4-Lite interface to the registers were decided locally.
module tdw_writeback
  import tdw_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite register slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Descriptor memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // Transmit engine side
  output logic             tx_start,
  output logic             tx_final_desc,
  output logic             tx_abort,
  input  wire tdw_txev_t   tx_ev,
  output logic             irq
);
  // ==========================================================
  // State
  tdw_state_t  st_q, st_d;
  logic [31:0] base_q, base_d, ctrl_word_q, ctrl_word_d;
  logic        en_q, en_d, final_q, final_d;
  logic        cdrop_q, cdrop_d, nocar_q, nocar_d, late_q, late_d;
  logic        abort_q, abort_d, starve_q, starve_d, post_q, post_d;
  logic [4:0]  coll_q, coll_d;
  logic [31:0] wb_q, wb_d;
  logic [IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
  logic        req_q, req_d, we_q, we_d, start_q, start_d, ab_q, ab_d, irq_q, irq_d;
  logic [31:0] addr_q, addr_d, wdat_q, wdat_d;
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [31:0] packed_w;
  logic [2:0]  ev;

  tdw_status_pack u_pack (
    .final_desc          (final_q),
    .carrier_dropped     (cdrop_q),
    .no_carrier          (nocar_q),
    .late_collision      (late_q),
    .retry_limit_abort   (abort_q),
    .collision_tally     (coll_q[3:0]),
    .fifo_starved        (starve_q),
    .start_postponed     (post_q),
    .tx_desc_status_word (packed_w)
  );

  // ==========================================================
  // Descriptor walk
  always_comb begin
    st_d = st_q; ctrl_word_d = ctrl_word_q; base_d = base_q;
    final_d = final_q; cdrop_d = cdrop_q; nocar_d = nocar_q; late_d = late_q;
    abort_d = abort_q; starve_d = starve_q; post_d = post_q; coll_d = coll_q;
    wb_d = wb_q; req_d = req_q; we_d = we_q; addr_d = addr_q; wdat_d = wdat_q;
    start_d = 1'b0; ab_d = 1'b0; ev = 3'b000;
    case (st_q)
      ST_IDLE: if (en_q) begin
        req_d = 1'b1; we_d = 1'b0; addr_d = base_q + OFF_STATUS; st_d = ST_FETCH;
      end
      ST_FETCH: if (mem_ack) begin
        req_d = 1'b0;
        if (mem_rdata[BIT_HOLDER]) begin
          req_d = 1'b1; addr_d = base_q + OFF_CONTROL; st_d = ST_WAITF;
        end else begin
          st_d = ST_IDLE;
        end
      end
      ST_WAITF: if (mem_ack) begin
        req_d = 1'b0; ctrl_word_d = mem_rdata;
        final_d = mem_rdata[BIT_FINAL_DESC];
        if (mem_rdata[BIT_FIRST_DESC]) begin
          cdrop_d = 1'b0; nocar_d = 1'b0; late_d = 1'b0; abort_d = 1'b0;
          starve_d = 1'b0; post_d = 1'b0; coll_d = 5'h00;
        end
        start_d = 1'b1; st_d = ST_BUSY;
      end
      ST_BUSY: begin
        if (tx_ev.carrier_dropped) cdrop_d = 1'b1;
        if (tx_ev.no_carrier) nocar_d = 1'b1;
        if (tx_ev.late_collision) late_d = 1'b1;
        if (tx_ev.fifo_starved) starve_d = 1'b1;
        if (tx_ev.start_postponed) post_d = 1'b1;
        if (tx_ev.collision && !abort_q) begin
          coll_d = coll_q + 5'h01;
          if (coll_q + 5'h01 >= RETRY_LIMIT) begin
            abort_d = 1'b1; ab_d = 1'b1;
          end
        end
        if (tx_ev.frame_end || abort_d) st_d = ST_WBACK;
      end
      ST_WBACK: begin
        wb_d = packed_w; req_d = 1'b1; we_d = 1'b1;
        addr_d = base_q + OFF_STATUS; wdat_d = packed_w; st_d = ST_WAITW;
      end
      ST_WAITW: if (mem_ack) begin
        req_d = 1'b0; we_d = 1'b0;
        base_d = base_q + {26'h0, DESC_WORDS, 2'b00};
        ev = {abort_q & final_q, packed_w[BIT_ANY_ERR], final_q};
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // ==========================================================
  // AXI4-Lite slave and interrupts
  always_comb begin
    aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q; bv_d = bv_q; br_d = br_q;
    rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
    en_d = en_q; imask_d = imask_q; ist_d = ist_q;
    if (s_awvalid && !aw_q && !bv_q) begin aw_d = 1'b1; awa_d = s_awaddr; end
    if (s_wvalid && !w_q && !bv_q) begin w_d = 1'b1; wd_d = s_wdata; end
    if (aw_q && w_q && !bv_q) begin
      aw_d = 1'b0; w_d = 1'b0; bv_d = 1'b1; br_d = RESP_OKAY;
      if (awa_q == REG_CTRL) en_d = wd_q[0];
      else if (awa_q == REG_BASE) br_d = RESP_OKAY;
      else if (awa_q == REG_IRQ) ist_d = ist_q & ~wd_q[IRQ_W-1:0];
      else if (awa_q == REG_MASK) imask_d = wd_q[IRQ_W-1:0];
      else if (awa_q == REG_STAT || awa_q == REG_LAST_WB) br_d = RESP_OKAY;
      else br_d = RESP_SLVERR;
    end
    if (bv_q && s_bready) bv_d = 1'b0;
    ist_d = ist_d | ev;
    if (s_arvalid && !rv_q) begin
      rv_d = 1'b1; rr_d = RESP_OKAY; rd_d = 32'h0000_0000;
      if (s_araddr == REG_CTRL) rd_d = {31'h0, en_q};
      else if (s_araddr == REG_BASE) rd_d = base_q;
      else if (s_araddr == REG_STAT) rd_d = {29'h0, st_q};
      else if (s_araddr == REG_IRQ) rd_d = {29'h0, ist_q};
      else if (s_araddr == REG_MASK) rd_d = {29'h0, imask_q};
      else if (s_araddr == REG_LAST_WB) rd_d = wb_q;
      else rr_d = RESP_SLVERR;
    end else if (rv_q && s_rready) begin
      rv_d = 1'b0;
    end
    irq_d = |(ist_d & imask_d);
  end

  logic base_wr;
  assign base_wr = aw_q && w_q && !bv_q && awa_q == REG_BASE && st_q == ST_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE; base_q <= 32'h0000_0000; ctrl_word_q <= 32'h0000_0000;
      en_q <= 1'b0; final_q <= 1'b0; cdrop_q <= 1'b0; nocar_q <= 1'b0;
      late_q <= 1'b0; abort_q <= 1'b0; starve_q <= 1'b0; post_q <= 1'b0;
      coll_q <= 5'h00; wb_q <= 32'h0000_0000; ist_q <= '0; imask_q <= '0;
      req_q <= 1'b0; we_q <= 1'b0; addr_q <= 32'h0000_0000; wdat_q <= 32'h0000_0000;
      start_q <= 1'b0; ab_q <= 1'b0; irq_q <= 1'b0;
      aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 8'h00; wd_q <= 32'h0000_0000;
      bv_q <= 1'b0; br_q <= RESP_OKAY; rv_q <= 1'b0; rd_q <= 32'h0000_0000;
      rr_q <= RESP_OKAY;
    end else begin
      st_q <= st_d; base_q <= base_wr ? wd_q : base_d; ctrl_word_q <= ctrl_word_d;
      en_q <= en_d; final_q <= final_d; cdrop_q <= cdrop_d; nocar_q <= nocar_d;
      late_q <= late_d; abort_q <= abort_d; starve_q <= starve_d; post_q <= post_d;
      coll_q <= coll_d; wb_q <= wb_d; ist_q <= ist_d; imask_q <= imask_d;
      req_q <= req_d; we_q <= we_d; addr_q <= addr_d; wdat_q <= wdat_d;
      start_q <= start_d; ab_q <= ab_d; irq_q <= irq_d;
      aw_q <= aw_d; w_q <= w_d; awa_q <= awa_d; wd_q <= wd_d;
      bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rd_q <= rd_d; rr_q <= rr_d;
    end
  end

  assign s_awready = s_awvalid && !aw_q && !bv_q;
  assign s_wready  = s_wvalid && !w_q && !bv_q;
  assign s_arready = s_arvalid && !rv_q;
  assign s_bvalid = bv_q;
  assign s_bresp  = br_q;
  assign s_rvalid = rv_q;
  assign s_rdata  = rd_q;
  assign s_rresp  = rr_q;
  assign mem_req = req_q;
  assign mem_we = we_q;
  assign mem_addr = addr_q;
  assign mem_wdata = wdat_q;
  assign tx_start = start_q;
  assign tx_final_desc = final_q;
  assign tx_abort = ab_q;
  assign irq = irq_q;

  // ==========================================================
  // Checks
  sequence wb_issue_s;
    st_q == ST_WBACK;
  endsequence
  sequence wb_out_s;
    ##1 mem_req && mem_we && !mem_wdata[BIT_HOLDER];
  endsequence

  holder_clear_a : assert property (@(posedge aclk) disable iff (!aresetn)
    wb_issue_s |-> wb_out_s) else $error("writeback keeps holder bit");
  err_sum_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (mem_req && mem_we) |-> mem_wdata[BIT_ANY_ERR] == (mem_wdata[1] | (|mem_wdata[11:8])))
    else $error("error summary mismatch");
  nonfinal_zero_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (mem_req && mem_we && !final_q) |-> mem_wdata == 32'h0000_0000)
    else $error("status in non-final descriptor");
  retry_abort_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == ST_BUSY && tx_ev.collision && coll_q == 5'h0f && !abort_q)
    |=> tx_abort && abort_q) else $error("no abort after 16 retries");
  tally_inc_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == ST_BUSY && tx_ev.collision && !abort_q) |=> coll_q == $past(coll_q) + 5'h01)
    else $error("collision tally not counted");
  starve_set_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == ST_BUSY && tx_ev.fifo_starved) |=> starve_q) else $error("underflow lost");
  drop_set_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == ST_BUSY && tx_ev.carrier_dropped) |=> cdrop_q) else $error("carrier drop lost");
  end_wb_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == ST_BUSY && tx_ev.frame_end) |-> ##2 mem_req && mem_we)
    else $error("no writeback after frame end");
endmodule : tdw_writeback

// File: sim/tdw_mem_model.sv
module tdw_mem_model
  import tdw_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Shared descriptor memory, one word per entry
  logic [31:0] mem [0:63];
  logic [2:0]  wait_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_ack   <= 1'b0;
      wait_q    <= 3'h0;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_req && !mem_ack && wait_q >= (slow ? 3'h4 : 3'h0)) begin
      mem_ack <= 1'b1;
      wait_q  <= 3'h0;
      if (mem_we) begin
        mem[mem_addr[7:2]] <= mem_wdata;
      end else begin
        mem_rdata <= mem[mem_addr[7:2]];
      end
    end else begin
      mem_ack   <= 1'b0;
      wait_q    <= mem_req ? wait_q + 3'h1 : 3'h0;
      // Stale data is inverted every cycle without an acknowledge, wait cycles included, instead of holding the last word
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : tdw_mem_model

// File: sim/tx_descriptor_status_writeback_tb.sv
module tx_descriptor_status_writeback_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tdw_pkg::*;
  logic        aclk, aresetn, slow, mem_req, mem_we, mem_ack, irq;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic        tx_start, tx_final_desc, tx_abort;
  logic [7:0]  s_awaddr, s_araddr;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, resp;
  logic [31:0] s_wdata, s_rdata, mem_addr, mem_wdata, mem_rdata, rd;
  tdw_txev_t   tx_ev;
  int          fail_count, samples_checked, cycles, aborts, starts;

  tdw_writeback u_dut (.*);
  tdw_mem_model u_mem (.*);

  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;

  // ==========================================================
  // Verdict and hang guard
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge aclk) begin
    cycles++;
    if (tx_abort) aborts++;
    if (tx_start) starts++;
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // ==========================================================
  // AXI4-Lite master
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      aw_ok = aw_ok | s_awready;
      w_ok = w_ok | s_wready;
      @(posedge aclk);
      if (aw_ok) s_awvalid <= 1'b0;
      if (w_ok) s_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_bvalid);
    resp = s_bresp;
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_arready);
    @(posedge aclk);
    s_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_rvalid);
    rd = s_rdata;
    resp = s_rresp;
    @(posedge aclk);
  endtask : axi_read

  // ==========================================================
  // Transmit engine events
  task automatic pulse(input logic [6:0] e);
    tx_ev <= tdw_txev_t'(e);
    @(posedge aclk);
    tx_ev <= '0;
    @(posedge aclk);
  endtask : pulse

  task automatic frame(input int ncoll, input logic [6:0] e, input logic endf,
                       input logic fin, input int idx, input logic [31:0] exp);
    // Hand the descriptor over only when this frame is ready to follow it
    @(negedge aclk);
    u_mem.mem[idx] = 32'h8000_0000;
    do @(negedge aclk); while (!tx_start);
    check("final_desc", tx_final_desc, fin);
    @(posedge aclk);
    pulse(e);
    repeat (ncoll) pulse(7'h02);
    if (endf) pulse(7'h01);
    do @(negedge aclk); while (u_mem.mem[idx][31]);
    check("status_word", u_mem.mem[idx], exp);
    @(posedge aclk);
  endtask : frame

  initial begin
    {aresetn, slow, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0000_0000;
    s_wstrb = 4'hf;
    tx_ev = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // Response readies stay high: each answer is taken at its valid edge
    s_bready <= 1'b1;
    s_rready <= 1'b1;
    @(posedge aclk);
    axi_read(REG_CTRL);
    check("ctrl_reset", rd, 32'h0000_0000);
    axi_read(REG_IRQ);
    check("irq_reset", rd, 32'h0000_0000);
    check("irq_pin", irq, 1'b0);
    axi_read(8'h20);
    check("rresp_unmapped", resp, RESP_SLVERR);
    axi_write(8'h24, 32'h0000_0001);
    check("bresp_unmapped", resp, RESP_SLVERR);
    for (int i = 0; i < 3; i++) begin
      // Host keeps each descriptor until its frame task hands it over
      u_mem.mem[16+4*i] = 32'h0000_0000;
      u_mem.mem[17+4*i] = (i == 2) ? 32'h2000_0000 : 32'h6000_0000;
    end
    u_mem.mem[28] = 32'h0000_0000;
    axi_write(REG_BASE, 32'h0000_0040);
    axi_write(REG_MASK, 32'h0000_0007);
    axi_read(REG_MASK);
    check("mask_rw", rd, 32'h0000_0007);
    axi_write(REG_CTRL, 32'h0000_0001);
    frame(2, 7'h14, 1'b1, 1'b1, 16, 32'h0000_8211);
    axi_read(REG_LAST_WB);
    check("last_wb", rd, 32'h0000_8211);
    axi_read(REG_IRQ);
    check("irq_stat", rd, 32'h0000_0003);
    check("irq_pin", irq, 1'b1);
    axi_write(REG_IRQ, 32'h0000_0003);
    axi_read(REG_IRQ);
    check("irq_w1c", rd, 32'h0000_0000);
    check("irq_pin", irq, 1'b0);
    slow <= 1'b1;
    frame(16, 7'h68, 1'b0, 1'b1, 20, 32'h0000_8D02);
    check("abort_pulses", aborts, 1);
    axi_read(REG_IRQ);
    check("irq_abort", rd, 32'h0000_0007);
    axi_write(REG_MASK, 32'h0000_0000);
    axi_read(REG_MASK);
    check("irq_masked", irq, 1'b0);
    axi_write(REG_MASK, 32'h0000_0004);
    axi_read(REG_MASK);
    check("irq_unmasked", irq, 1'b1);
    axi_write(REG_IRQ, 32'h0000_0007);
    slow <= 1'b0;
    frame(0, 7'h10, 1'b1, 1'b0, 24, 32'h0000_0000);
    axi_read(REG_IRQ);
    check("irq_not_final", rd, 32'h0000_0000);
    repeat (40) @(posedge aclk);
    check("host_owned_skip", starts, 3);
    check("host_word_kept", u_mem.mem[28], 32'h0000_0000);
    conclude();
  end
endmodule : tx_descriptor_status_writeback_tb
